// ### bench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import uproc_port_pkg::*;
    logic clk = 0, rst_n = 0, dev_reset_req = 0, req_valid = 0, irq_src = 0;
    req_t req = '0;
    logic req_ready, done, irq, async_reset_n, irq_out_n;
    logic [7:0] rdata, data_in, dev_d;
    pins_t pins;
    logic [8:0] q [$];
    logic [7:0] sh [2048];
    logic [10:0] ad [8];
    int n_errors = 0, comparisons = 0;
    always #2.5 clk = ~clk;
    assign data_in = pins.data_oe ? pins.data_out : dev_d;
    uproc_port_host u_uproc_port_host (.clk(clk), .rst_n(rst_n), .dev_reset_req(dev_reset_req), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata), .done(done), .irq(irq), .pins(pins),
        .async_reset_n(async_reset_n), .data_in(data_in), .irq_out_n(irq_out_n));
    uproc_dev_model u_uproc_dev_model (.pins(pins), .bus(data_in), .async_reset_n(async_reset_n),
        .irq_src(irq_src), .dev_d(dev_d), .irq_out_n(irq_out_n));
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic acc(input logic w, input logic [10:0] a, input logic [7:0] wd);
        int i;
        i = 0;
        req <= {w, a, wd};
        req_valid <= 1'b1;
        while (req_ready !== 1'b1) begin
            if (++i > 60) begin
                n_errors++;
                summarize();
            end
            tick(1);
        end
        tick(1);
        req_valid <= 1'b0;
        q.push_back({w, sh[a]});
        tick(1);
        if (w) sh[a] = wd;
    endtask
    task automatic irq_is(input logic e);
        tick(30);
        check("irq", {7'h00, irq}, {7'h00, e});
    endtask
    always @(posedge clk) begin
        #1;
        if (done === 1'b1 && q.size() > 0) begin
            if (!q[0][8]) check("rdata", rdata, q[0][7:0]);
            q.delete(0);
        end
    end
    initial begin
        void'($urandom(32'h4E88A5A7));
        tick(16);
        rst_n <= 1'b1;
        tick(2);
        foreach (ad[i]) begin
            ad[i] = {i[0], i[2:1], 8'($urandom_range(253))};
            acc(1'b1, ad[i], 8'($urandom));
        end
        foreach (ad[i]) acc(1'b0, ad[i], 8'h00);
        acc(1'b1, 11'h0FF, 8'h00);
        irq_src <= 1'b1;
        irq_is(1'b1);
        acc(1'b1, 11'h0FF, 8'h01);
        irq_is(1'b0);
        acc(1'b1, 11'h0FF, 8'h00);
        irq_is(1'b1);
        acc(1'b0, 11'h0FE, 8'h00);
        irq_is(1'b0);
        dev_reset_req <= 1'b1;
        acc(1'b0, ad[1], 8'h00);
        tick(40);
        dev_reset_req <= 1'b0;
        foreach (sh[i]) sh[i] = 8'h00;
        acc(1'b0, ad[0], 8'h00);
        for (int k = 0; k < 100 && q.size() > 0; k++) tick(1);
        if (q.size() > 0) n_errors++;
        summarize();
    end
endmodule
bind uproc_port_host uproc_port_host_asserts u_uproc_port_host_asserts (.clk(clk), .rst_n(rst_n), .pins(pins),
    .async_reset_n(async_reset_n), .done(done));
`default_nettype wire

// ### bench/uproc_dev_model.sv
`default_nettype none
module uproc_dev_model
    import uproc_port_pkg::*;
(
    input wire uproc_port_pkg::pins_t pins, // host pins
    input wire logic [7:0] bus, // data wire
    input wire logic async_reset_n, // reset
    input wire logic irq_src, // event
    output logic [7:0] dev_d, // drive
    output logic irq_out_n // pulled up
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] m [2048];
    logic [7:0] lat;
    logic [7:0] last;
    logic pend;
    wire [10:0] a = {pins.test_space_select, pins.addr[9:8], lat};
    wire drv = !pins.read_strobe_n && !pins.chip_select_n;
    wire ack = drv && a == 11'h0FE;
    always @* if (pins.ale) lat = pins.addr[7:0];
    always @(posedge pins.write_strobe_n or negedge async_reset_n)
        if (!async_reset_n) foreach (m[i]) m[i] <= 8'h00;
        else if (!pins.chip_select_n) m[a] <= bus;
    // released bus shows the inverse, never a stale copy
    always @(negedge drv) last = m[a];
    assign dev_d = drv ? m[a] : ~last;
    always @(posedge irq_src or posedge ack or negedge async_reset_n)
        pend <= async_reset_n && !ack;
    assign irq_out_n = !(pend && !m[11'h0FF][0]);
endmodule
`default_nettype wire

// ### bench/uproc_port_host_asserts.sv
`default_nettype none
module uproc_port_host_asserts
    import uproc_port_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire uproc_port_pkg::pins_t pins, // pins
    input wire logic async_reset_n, // dev reset
    input wire logic done // end pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire cs = !pins.chip_select_n;
    wire rd = !pins.read_strobe_n;
    wire wr = !pins.write_strobe_n;
    sequence s_quiet; (cs && !rd && !wr) [*4]; endsequence
    sequence s_strobe; (cs && (rd ^ wr)) [*8]; endsequence
    walk_cs_a: assert property ($rose(cs) |-> s_quiet ##1 s_strobe ##1 s_quiet ##1 !cs)
        else $error("access phases wrong");
    strobe_cs_a: assert property ((rd || wr) |-> cs) else $error("strobe unselected");
    reset_cs_a: assert property (!async_reset_n |-> !cs && !rd && !wr) else $error("select in reset");
    done_end_a: assert property (done |-> !cs && $past(cs)) else $error("done off end");
endmodule
`default_nettype wire

// ### rtl/uproc_port_host.sv
// How it works
// [RQ1] chip select stays low from address setup through strobe and hold of every access.
// [RQ2] while the device reset is held low, chip select is held high.
// [RQ3] in strobe-only use chip select would follow the inverted reset; here it is always driven, so RQ2 applies.
// [RQ4] on a read the device drives the data bus while read strobe and chip select are low; we sample it then.
// [RQ5] the device captures write data on the rising write strobe with chip select low.
// [RQ6] address bits 9:8 pick the channel and bits 7:0 the register in it.
// [RQ7] the test space line high selects test registers, low the normal ones.
// [RQ8] the device resets asynchronously while its reset input is low.
// [RQ9] the device latches the low address while latch enable is low, transparent while high.
// [RQ10] the device pulls the interrupt low while an unmasked source is active.
// [RQ11] the interrupt is open drain and is released once acknowledged by a register access.
// [RQ12] the device keeps the data bus released except during a read.
`default_nettype none
module uproc_port_host
    import uproc_port_pkg::*;
(
    input wire logic clk, // 200 MHz
    input wire logic rst_n, // async, active low
    input wire logic dev_reset_req, // hold device in reset while high
    input wire uproc_port_pkg::req_t req, // access request
    input wire logic req_valid, // request offered
    output logic req_ready, // request taken this cycle
    output logic [uproc_port_pkg::DATA_W-1:0] rdata, // read data
    output logic done, // one-cycle pulse, access finished
    output logic irq, // device interrupt, synchronised
    output uproc_port_pkg::pins_t pins, // bus pins toward device
    output logic async_reset_n, // device reset
    input wire logic [uproc_port_pkg::DATA_W-1:0] data_in, // data bus level
    input wire logic irq_out_n // device interrupt pin level
);
    import uproc_port_pkg::*;

    ctl_t q, d;
    logic rst_dev_q;

    localparam pins_t PINS_IDLE = '{chip_select_n: 1'b1, read_strobe_n: 1'b1, write_strobe_n: 1'b1,
                                    ale: 1'b1, test_space_select: 1'b0, addr: '0, data_out: '0,
                                    data_oe: 1'b0};

    always_comb begin
        d = q;
        d.done = 1'b0;
        // pin is open drain: pulled-up high means no request
        d.irq_sync = {q.irq_sync[1:0], ~irq_out_n};
        if (q.irq_sync[2] == q.irq_sync[1]) begin
            d.irq = q.irq_sync[2]; // [RQ10] [RQ11]
        end
        case (q.st)
            ST_IDLE: begin
                d.pins = PINS_IDLE;
                if (req_valid && !rst_dev_q) begin
                    d.req = req;
                    d.cnt = CNT_W'(LATCH_CYC);
                    d.st = ST_LATCH;
                    d.pins.addr = {req.channel, req.reg_addr}; // [RQ6]
                    d.pins.test_space_select = req.test_space; // [RQ7]
                    d.pins.ale = 1'b1; // [RQ9]
                end
            end
            ST_LATCH: begin
                d.cnt = q.cnt - 1'b1;
                if (q.cnt == CNT_W'(1)) begin
                    d.pins.ale = 1'b0; // [RQ9] address now held by device latch
                    d.pins.chip_select_n = 1'b0; // [RQ1]
                    d.pins.data_oe = q.req.write; // [RQ12]
                    d.pins.data_out = q.req.wdata;
                    d.cnt = CNT_W'(SETUP_CYC);
                    d.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                d.cnt = q.cnt - 1'b1;
                if (q.cnt == CNT_W'(1)) begin
                    d.pins.read_strobe_n = q.req.write;
                    d.pins.write_strobe_n = ~q.req.write;
                    d.cnt = CNT_W'(STROBE_CYC);
                    d.st = ST_STROBE;
                end
            end
            ST_STROBE: begin
                d.cnt = q.cnt - 1'b1;
                if (q.cnt == CNT_W'(1)) begin
                    // sample at strobe end; bus has settled for the whole strobe
                    if (!q.req.write) begin
                        d.rdata = data_in; // [RQ4]
                    end
                    d.pins.read_strobe_n = 1'b1;
                    d.pins.write_strobe_n = 1'b1; // [RQ5] rising edge captures data
                    d.cnt = CNT_W'(HOLD_CYC);
                    d.st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                d.cnt = q.cnt - 1'b1;
                if (q.cnt == CNT_W'(1)) begin
                    d.pins = PINS_IDLE; // [RQ1] chip select released only after hold
                    d.done = 1'b1;
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
                d.pins = PINS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: ST_IDLE, cnt: '0, req: '0, pins: PINS_IDLE, rdata: '0, done: 1'b0,
                   irq_sync: '0, irq: 1'b0};
            rst_dev_q <= 1'b1;
        end else begin
            q <= d;
            // reset only changes between accesses, never on the edge that takes a request,
            // so chip select is high throughout
            if (q.st == ST_IDLE && !(req_valid && !rst_dev_q)) begin
                rst_dev_q <= dev_reset_req; // [RQ2] [RQ3] [RQ8]
            end
        end
    end

    assign req_ready = (q.st == ST_IDLE) && !rst_dev_q;
    assign rdata = q.rdata;
    assign done = q.done;
    assign irq = q.irq;
    assign pins = q.pins;
    assign async_reset_n = ~rst_dev_q;
endmodule
`default_nettype wire

// ### rtl/uproc_port_pkg.sv
`default_nettype none
package uproc_port_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int CHAN_LSB = 8;
    localparam int CHAN_W = 2;
    // access timing, in ns as the host chooses to run it
    localparam int CLK_NS = 5;
    localparam int SETUP_NS = 20;
    localparam int STROBE_NS = 40;
    localparam int HOLD_NS = 20;
    localparam int LATCH_NS = 20;
    // least times round up
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int LATCH_CYC = (LATCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;

    typedef struct packed {
        logic write;
        logic test_space;
        logic [CHAN_W-1:0] channel;
        logic [7:0] reg_addr;
        logic [DATA_W-1:0] wdata;
    } req_t;

    typedef struct packed {
        logic chip_select_n;
        logic read_strobe_n;
        logic write_strobe_n;
        logic ale;
        logic test_space_select;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data_out;
        logic data_oe;
    } pins_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LATCH = 3'b001,
        ST_SETUP = 3'b011,
        ST_STROBE = 3'b010,
        ST_HOLD = 3'b110
    } state_t;

    typedef struct packed {
        state_t st;
        logic [CNT_W-1:0] cnt;
        req_t req;
        pins_t pins;
        logic [DATA_W-1:0] rdata;
        logic done;
        logic [2:0] irq_sync;
        logic irq;
    } ctl_t;
endpackage
`default_nettype wire
